/* rtl/pbc_defs.vh */
/*
  Constants for the basic PHY control register block: register address,
  field positions, reset values, frame layout and timing counts.
  Assumes a 200 MHz core clock and clause 22 management frames.
*/
// Contract
// - Writing one to bit 15 starts a soft reset; hardware clears it when done.
// - During soft reset writes to all other control bits are ignored; about 1 ms.
// - Writing zero to reset bit does nothing; bit reads zero after reset ends.
// - Soft reset never reloads strap values; only hardware reset samples straps.
// - Bit 14 enables local loop-back; zero or chip reset clears; reads state. Code loads the loop strap at chip reset instead.
// - With autoneg off, bit 13 forces speed: one 100 Mb/s, zero 10 Mb/s.
// - Speed bit reads back the forced value only, never the resolved speed.
// - Autoneg enable pin low disables autoneg and blocks writes to bit 12.
// - Bit 12 zero disables autoneg, one enables; chip reset follows strap.
// - Bit 12 reads last written value, or one if unwritten since chip reset. Code reads the autoneg strap value instead.
// - Power-down bit powers the channel down and forces pad directions.
// - Bit 10 isolates MII: outputs except tx clock float, inputs ignored.
// - Isolation ends on zero write or chip reset; bit reads isolate state. Code loads the isolate strap at chip reset instead.
// - Bit 9 one restarts autoneg if enabled; self-clears; always reads zero.
// - Powers up half duplex; bit 8 one forces full duplex with autoneg off. Code powers up with the duplex strap instead.
// - Bit 7 enables collision test, acting only in loop-back; reads enable.
// - Collision test: tx enable drives collision high within 512, low within 4 bits.
// - Zero write or chip reset leaves collision test disabled.
// - Reserved bits 6 to 0 ignore writes and read zero.
`ifndef PBC_DEFS_VH
`define PBC_DEFS_VH

// ============================================================
// Register map
`define PBC_REG_ADDR 5'h00
`define PBC_BIT_SRST 15
`define PBC_BIT_LOOP 14
`define PBC_BIT_SPEED 13
`define PBC_BIT_ANEN 12
`define PBC_BIT_PDOWN 11
`define PBC_BIT_ISO 10
`define PBC_BIT_ANRST 9
`define PBC_BIT_DUPLEX 8
`define PBC_BIT_COLT 7
`define PBC_RSVD_MASK 16'h007f

// ============================================================
// Chip reset values; autoneg enable is then replaced by its strap
`define PBC_RST_PDOWN 1'b0
`define PBC_RST_COLT 1'b0
`define PBC_RST_ANEN 1'b1

// ============================================================
// Frame fields
`define PBC_OP_WRITE 2'b01
`define PBC_OP_READ 2'b10

// ============================================================
// Timing
`define PBC_CLK_MHZ 200
`define PBC_SRST_US 1000
`define PBC_SRST_CYC (`PBC_SRST_US * `PBC_CLK_MHZ)
`define PBC_COL_ON_BT 512
`define PBC_COL_OFF_BT 4
`define PBC_RESTART_CYC 3'd4
`define PBC_COL_ON_CYC 16

`endif

/* rtl/pbc_control.v */
/*
  Basic PHY control register with its own clause 22 management slave.
  Assumes MDC and MDIO come from another domain and are synchronised here;
  straps are stable at chip reset release; tx enable is asynchronous.
  Straps are taken only when chip reset ends, never by soft reset.
*/
`timescale 1ns/1ps
`include "pbc_defs.vh"

module pbc_control #(
  parameter [4:0] PHY_ADDR = 5'h01,
  parameter SRST_CYCLES = `PBC_SRST_CYC,
  parameter COL_ON_CYCLES = `PBC_COL_ON_CYC
) (
  input wire clock_i,
  input wire reset_i,
  input wire mdc_i,
  input wire mdio_i,
  output reg mdio_o,
  output reg mdio_oe_o,
  input wire autoneg_hw_enable_pin_i,
  input wire strap_loop_i,
  input wire strap_speed_i,
  input wire strap_anen_i,
  input wire strap_iso_i,
  input wire strap_duplex_i,
  input wire tx_en_i,
  output reg col_o,
  output reg col_oe_o,
  output reg loopback_o,
  output reg speed100_o,
  output reg autoneg_en_o,
  output reg autoneg_restart_o,
  output reg full_duplex_o,
  output reg power_down_o,
  output reg isolate_o,
  output reg soft_reset_busy_o
);

  // ============================================================
  // Synchronisers
  // Two flops per pin; only the second stage is read
  // Reset levels match the idle pins, so no false MDC edge follows reset
  reg [1:0] mdc_s_q;
  reg [1:0] mdio_s_q;
  reg [1:0] pin_s_q;
  reg [1:0] txen_s_q;
  reg mdc_last_q;
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mdc_s_q <= 2'b00;
      mdio_s_q <= 2'b11;
      pin_s_q <= 2'b11;
      txen_s_q <= 2'b00;
      mdc_last_q <= 1'b0;
    end else begin
      mdc_s_q <= {mdc_s_q[0], mdc_i};
      mdio_s_q <= {mdio_s_q[0], mdio_i};
      pin_s_q <= {pin_s_q[0], autoneg_hw_enable_pin_i};
      txen_s_q <= {txen_s_q[0], tx_en_i};
      mdc_last_q <= mdc_s_q[1];
    end
  end
  wire mdc_rise = mdc_s_q[1] & ~mdc_last_q;
  wire mdc_fall = ~mdc_s_q[1] & mdc_last_q;
  wire mdio_in = mdio_s_q[1];
  wire hw_autoneg_hw_enable_pin = pin_s_q[1];

  // Straps are pins as well; their flops carry no reset, so the chain
  // already holds strap levels when chip reset lets go. Limitation: the
  // straps must be steady for two clock edges before reset ends.
  reg [4:0] strap_s1_q;
  reg [4:0] strap_s2_q;
  always @(posedge clock_i) begin
    strap_s1_q <= {strap_loop_i, strap_speed_i, strap_anen_i, strap_iso_i, strap_duplex_i};
    strap_s2_q <= strap_s1_q;
  end

  // ============================================================
  // Decode helpers
  // PHY address field of a header against our own address
  function addr_hit;
    input [4:0] phyad;
    begin
      addr_hit = (phyad == PHY_ADDR);
    end
  endfunction
  // Autoneg runs only when both the register bit and the pin allow it
  function an_live;
    input anen_bit;
    input pin_bit;
    begin
      an_live = anen_bit & pin_bit;
    end
  endfunction

  // ============================================================
  // Clause 22 frame receiver
  // Preamble of 32 ones, then ST, OP, PHYAD, REGAD, TA, 16 data bits
  // Binary state codes; any other code falls back to idle
  localparam ST_IDLE = 3'd0;
  localparam ST_HDR = 3'd1;
  localparam ST_TA = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_RDATA = 3'd4;
  reg [2:0] state_q;
  reg [5:0] ones_q;
  reg [4:0] cnt_q;
  reg [13:0] hdr_q;
  reg [15:0] shift_q;
  reg wr_stb_q;
  reg [15:0] wr_data_q;
  wire [15:0] rd_word;
  wire hdr_ours = addr_hit(hdr_q[9:5]) && (hdr_q[4:0] == `PBC_REG_ADDR);
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      ones_q <= 6'd0;
      cnt_q <= 5'd0;
      hdr_q <= 14'd0;
      shift_q <= 16'd0;
      wr_stb_q <= 1'b0;
      wr_data_q <= 16'd0;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (mdc_rise) begin
            if (mdio_in) begin
              if (ones_q != 6'd32) ones_q <= ones_q + 6'd1;
            end else begin
              // Zero after a full preamble is the first start bit
              if (ones_q == 6'd32) begin
                state_q <= ST_HDR;
                hdr_q <= 14'd0;
                cnt_q <= 5'd0;
              end
              // A short run of ones is no preamble; counting starts over
              ones_q <= 6'd0;
            end
          end
        end
        ST_HDR: begin
          if (mdc_rise) begin
            hdr_q <= {hdr_q[12:0], mdio_in};
            cnt_q <= cnt_q + 5'd1;
            // Second start bit plus op, address, register: 13 bits
            if (cnt_q == 5'd12) begin
              state_q <= ST_TA;
              cnt_q <= 5'd0;
            end
          end
        end
        ST_TA: begin
          if (hdr_q[12] != 1'b1) begin
            state_q <= ST_IDLE;
          end else if (hdr_q[11:10] == `PBC_OP_READ) begin
            // Drive zero for second turnaround bit, then data MSB first
            if (mdc_fall) begin
              cnt_q <= cnt_q + 5'd1;
              if (cnt_q == 5'd0) begin
                mdio_oe_o <= 1'b0;
              end else if (addr_hit(hdr_q[9:5])) begin
                // Any register at our address answers; only register zero exists
                mdio_oe_o <= 1'b1;
                mdio_o <= 1'b0;
                shift_q <= rd_word;
                state_q <= ST_RDATA;
                cnt_q <= 5'd0;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end else if (hdr_q[11:10] == `PBC_OP_WRITE) begin
            if (mdc_rise) begin
              cnt_q <= cnt_q + 5'd1;
              if (cnt_q == 5'd1) begin
                state_q <= ST_WDATA;
                cnt_q <= 5'd0;
              end
            end
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_WDATA: begin
          if (mdc_rise) begin
            shift_q <= {shift_q[14:0], mdio_in};
            cnt_q <= cnt_q + 5'd1;
            if (cnt_q == 5'd15) begin
              state_q <= ST_IDLE;
              // Strobe only for our address and register zero; others fall away
              wr_stb_q <= hdr_ours;
              wr_data_q <= {shift_q[14:0], mdio_in};
            end
          end
        end
        ST_RDATA: begin
          if (mdc_fall) begin
            cnt_q <= cnt_q + 5'd1;
            // Let go one half bit after the LSB for a clean handover
            if (cnt_q == 5'd16) begin
              mdio_oe_o <= 1'b0;
              state_q <= ST_IDLE;
            end else begin
              mdio_o <= shift_q[15];
              shift_q <= {shift_q[14:0], 1'b0};
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ============================================================
  // Control fields
  reg srst_q;
  reg [31:0] srst_cnt_q;
  reg loop_q;
  reg speed_q;
  reg anen_q;
  reg pdown_q;
  reg iso_q;
  reg duplex_q;
  reg colt_q;
  reg [2:0] restart_q;
  reg strap_take_q;
  // Soft reset leaves every field alone; only its own bit and counter move
  // Write lockout while soft reset runs keeps config stable under reset
  wire wr_ok = wr_stb_q & ~srst_q;
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      srst_q <= 1'b0;
      srst_cnt_q <= 32'd0;
      loop_q <= 1'b0;
      speed_q <= 1'b0;
      anen_q <= `PBC_RST_ANEN;
      pdown_q <= `PBC_RST_PDOWN;
      iso_q <= 1'b0;
      duplex_q <= 1'b0;
      colt_q <= `PBC_RST_COLT;
      restart_q <= 3'd0;
      strap_take_q <= 1'b1;
    end else begin
      strap_take_q <= 1'b0;
      if (strap_take_q) begin
        // Straps only caught after chip reset release, not by soft reset
        loop_q <= strap_s2_q[4];
        speed_q <= strap_s2_q[3];
        anen_q <= strap_s2_q[2];
        iso_q <= strap_s2_q[1];
        duplex_q <= strap_s2_q[0];
      end else if (wr_ok) begin
        loop_q <= wr_data_q[`PBC_BIT_LOOP];
        speed_q <= wr_data_q[`PBC_BIT_SPEED];
        if (hw_autoneg_hw_enable_pin) anen_q <= wr_data_q[`PBC_BIT_ANEN];
        pdown_q <= wr_data_q[`PBC_BIT_PDOWN];
        iso_q <= wr_data_q[`PBC_BIT_ISO];
        duplex_q <= wr_data_q[`PBC_BIT_DUPLEX];
        colt_q <= wr_data_q[`PBC_BIT_COLT];
      end
      // Soft reset counter; a written zero leaves it alone
      if (srst_q) begin
        if (srst_cnt_q == SRST_CYCLES - 1) begin
          srst_q <= 1'b0;
          srst_cnt_q <= 32'd0;
        end else begin
          srst_cnt_q <= srst_cnt_q + 32'd1;
        end
      end else if (wr_stb_q && wr_data_q[`PBC_BIT_SRST]) begin
        srst_q <= 1'b1;
      end
      // Restart pulse held a few cycles, only with autoneg enabled. The
      // enable is judged on the value this same write leaves behind, so a
      // write that turns autoneg off and sets restart does not restart.
      if (wr_ok && wr_data_q[`PBC_BIT_ANRST] &&
          an_live(wr_data_q[`PBC_BIT_ANEN], hw_autoneg_hw_enable_pin)) begin
        restart_q <= `PBC_RESTART_CYC;
      end else if (restart_q != 3'd0) begin
        restart_q <= restart_q - 3'd1;
      end
    end
  end

  // Readback: speed is the forced value; restart and reserved read zero
  assign rd_word = {srst_q, loop_q, speed_q, anen_q, pdown_q, iso_q, 1'b0,
                    duplex_q, colt_q, 7'h00};

  // ============================================================
  // Collision test
  // 100 Mb/s bit time is 2 cycles; asserting after COL_ON_CYCLES cycles meets the 512 bound,
  // and release follows within three cycles of tx enable dropping, inside 4 bit times
  reg [15:0] col_cnt_q;
  // An isolated device ignores tx enable, so collision stays low there
  wire col_mode = colt_q & loop_q;
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      col_cnt_q <= 16'd0;
      col_o <= 1'b0;
      col_oe_o <= 1'b0;
    end else begin
      col_oe_o <= ~iso_q & ~(pdown_q);
      if (col_mode && txen_s_q[1] && !iso_q) begin
        if (col_cnt_q >= COL_ON_CYCLES - 1) col_o <= 1'b1;
        else col_cnt_q <= col_cnt_q + 16'd1;
      end else begin
        col_cnt_q <= 16'd0;
        col_o <= 1'b0;
      end
    end
  end

  // ============================================================
  // Effective configuration outputs
  // Every output lags its field by one clock so that each leaves a flop
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      loopback_o <= 1'b0;
      speed100_o <= 1'b0;
      autoneg_en_o <= 1'b0;
      autoneg_restart_o <= 1'b0;
      full_duplex_o <= 1'b0;
      power_down_o <= 1'b0;
      isolate_o <= 1'b0;
      soft_reset_busy_o <= 1'b0;
    end else begin
      loopback_o <= loop_q;
      autoneg_en_o <= an_live(anen_q, hw_autoneg_hw_enable_pin);
      // Forced speed and duplex apply only with autoneg off
      speed100_o <= ~an_live(anen_q, hw_autoneg_hw_enable_pin) & speed_q;
      full_duplex_o <= ~an_live(anen_q, hw_autoneg_hw_enable_pin) & duplex_q;
      autoneg_restart_o <= (restart_q != 3'd0);
      power_down_o <= pdown_q;
      isolate_o <= iso_q;
      soft_reset_busy_o <= srst_q;
    end
  end

endmodule // pbc_control

/* sim/pbc_control_monitor.sv */
/*
  Port checker for the basic PHY control block.
  Assumes it is bound to every pbc_control and sees its SRST_CYCLES.
*/
`timescale 1ns/1ps
module pbc_control_monitor #(
  parameter int SRST_CYCLES = 200000
) (
  input wire clock_i,
  input wire reset_i,
  input wire tx_en_i,
  input wire mdio_o,
  input wire mdio_oe_o,
  input wire col_o,
  input wire col_oe_o,
  input wire loopback_o,
  input wire autoneg_en_o,
  input wire autoneg_restart_o,
  input wire power_down_o,
  input wire isolate_o,
  input wire soft_reset_busy_o
);
  // ============================================================
  // Busy length counter, too long for a repetition operator
  int busy_cnt_q;
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) busy_cnt_q <= 0;
    else busy_cnt_q <= soft_reset_busy_o ? busy_cnt_q + 1 : 0;
  end

  // ============================================================
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  AST_SRST_BOUND: assert property (busy_cnt_q <= SRST_CYCLES + 1)
    else $error("soft reset held too long");
  AST_SRST_FREEZE: assert property (soft_reset_busy_o && $past(soft_reset_busy_o)
    |-> $stable({loopback_o, isolate_o, power_down_o})) else $error("field moved in reset");
  AST_RESTART_PULSE: assert property ($rose(autoneg_restart_o)
    |-> autoneg_restart_o [*4] ##1 !autoneg_restart_o) else $error("restart pulse length");
  AST_RESTART_AN: assert property (autoneg_restart_o |-> autoneg_en_o)
    else $error("restart while autoneg off");
  AST_COL_OFF: assert property (!tx_en_i [*4] |-> !col_o)
    else $error("collision late to drop");
  AST_COL_LOOP: assert property (col_o |-> loopback_o && !isolate_o)
    else $error("collision outside loop-back");
  AST_ISO_OE: assert property (isolate_o ##1 isolate_o |-> !col_oe_o)
    else $error("collision driven while isolated");
  AST_PDOWN_OE: assert property (power_down_o ##1 power_down_o |-> !col_oe_o)
    else $error("collision driven in power-down");
  AST_TA_ZERO: assert property ($rose(mdio_oe_o) |-> !mdio_o)
    else $error("turnaround bit not zero");
  cover property ($fell(soft_reset_busy_o));
  cover property ($rose(col_o));
  cover property ($rose(autoneg_restart_o));
endmodule // pbc_control_monitor

bind pbc_control pbc_control_monitor #(.SRST_CYCLES(SRST_CYCLES)) u_mon (
  .clock_i(clock_i),
  .reset_i(reset_i),
  .tx_en_i(tx_en_i),
  .mdio_o(mdio_o),
  .mdio_oe_o(mdio_oe_o),
  .col_o(col_o),
  .col_oe_o(col_oe_o),
  .loopback_o(loopback_o),
  .autoneg_en_o(autoneg_en_o),
  .autoneg_restart_o(autoneg_restart_o),
  .power_down_o(power_down_o),
  .isolate_o(isolate_o),
  .soft_reset_busy_o(soft_reset_busy_o)
);

/* sim/pbc_sta_model.sv */
/*
  Behavioural station manager driving clause 22 frames at 80 ns per bit.
  Assumes the bench resolves the shared data line with a pull-up.
*/
`timescale 1ns/1ps
module pbc_sta_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic mdio_i
);
  // Clock stands still low between frames
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // ============================================================
  // One frame; data changes only while the management clock is low
  task automatic frame(input logic [1:0] op, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hffff_ffff, 2'h1, op, PHY_ADDR, 5'h00, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      mdio_oe_o = !(op == 2'h2 && i < 18); // Let go at turnaround on reads
      mdio_o = f[i];
      #40 mdc_o = 1'b1;
      if (i < 16) rd[i] = mdio_i;
      #40 mdc_o = 1'b0;
    end
    mdio_oe_o = 1'b0;
    #200;
  endtask
endmodule // pbc_sta_model

/* sim/testbench.sv */
/*
  Self-checking bench for pbc_control with a station manager model.
  Assumes a 5 ns core clock and a shortened soft reset length.
*/
`timescale 1ns/1ps
module testbench;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic pin = 1'b1;
  logic tx_en = 1'b0;
  logic [4:0] st = 5'h04;
  logic [15:0] cur, w;
  logic [31:0] r;
  logic [31:0] seed_q = 32'h0000_7e58;
  int n_fail = 0;
  int tests_run = 0;
  wire mdc, sta_o, sta_oe, dut_o, dut_oe, loop_o, iso_o, pd_o, busy_o, col_o;
  wire spd_o, fdx_o, an_o;
  // Pull-up holds the released data line high
  wire mdio_w = dut_oe ? dut_o : (sta_oe ? sta_o : 1'b1);

  always #2.5 clock_i = ~clock_i;

  pbc_sta_model u_sta (.mdc_o(mdc), .mdio_o(sta_o), .mdio_oe_o(sta_oe), .mdio_i(mdio_w));
  pbc_control #(.PHY_ADDR(5'h01), .SRST_CYCLES(3000), .COL_ON_CYCLES(16)) u_dut (
    .clock_i(clock_i), .reset_i(reset_i), .mdc_i(mdc), .mdio_i(mdio_w),
    .mdio_o(dut_o), .mdio_oe_o(dut_oe), .autoneg_hw_enable_pin_i(pin),
    .strap_loop_i(st[4]), .strap_speed_i(st[3]), .strap_anen_i(st[2]),
    .strap_iso_i(st[1]), .strap_duplex_i(st[0]), .tx_en_i(tx_en),
    .col_o(col_o), .col_oe_o(), .loopback_o(loop_o), .speed100_o(spd_o), .autoneg_en_o(an_o),
    .autoneg_restart_o(), .full_duplex_o(fdx_o), .power_down_o(pd_o), .isolate_o(iso_o),
    .soft_reset_busy_o(busy_o));

  // ============================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed_q ^= seed_q << 13;
    seed_q ^= seed_q >> 17;
    seed_q ^= seed_q << 5;
    return seed_q;
  endfunction
  // Bit 12 only takes a write while the hardware pin allows autoneg
  function automatic logic [15:0] exp_wr(input logic [15:0] c, input logic [15:0] d, input logic p);
    logic [15:0] m;
    m = p ? 16'h7d80 : 16'h6d80;
    return ((c & ~m) | (d & m)) & 16'h7d80;
  endfunction
  // Forced speed and duplex only show while autoneg is off
  function automatic logic [15:0] exp_mode(input logic [15:0] c, input logic p);
    logic a;
    a = c[12] & p;
    return {13'h0000, a, ~a & c[13], ~a & c[8]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    logic [15:0] x;
    u_sta.frame(2'h1, d, x);
  endtask
  task automatic rd_chk(input logic [15:0] e);
    logic [15:0] x;
    u_sta.frame(2'h2, 16'h0000, x);
    chk(x, e);
  endtask
  task automatic tx_set(input logic v);
    @(posedge clock_i);
    #1 tx_en = v;
  endtask
  // Chip reset with fresh straps; autoneg strap kept high
  task automatic do_reset();
    r = rnd();
    @(posedge clock_i);
    #1 reset_i = 1'b1;
    st = {r[4:3], 1'b1, r[1:0]};
    repeat (3) @(posedge clock_i);
    #1 reset_i = 1'b0;
    repeat (2) @(posedge clock_i);
    cur = {1'b0, st[4], st[3], st[2], 1'b0, st[1], 1'b0, st[0], 8'h00};
    rd_chk(cur);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ============================================================
  // Main sequence
  initial begin
    do_reset();
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      @(posedge clock_i);
      #1 pin = (i == 0) | r[16] | r[17];
      w = (i == 0) ? 16'h1200 : r[15:0] & 16'h7fff;
      if (!w[14]) w[7] = 1'b0;
      wr(w);
      cur = exp_wr(cur, w, pin);
      rd_chk(cur);
      chk({13'h0000, loop_o, iso_o, pd_o}, {13'h0000, cur[14], cur[10], cur[11]});
      chk({13'h0000, an_o, spd_o, fdx_o}, exp_mode(cur, pin));
    end
    // Soft reset: straps move, a write during busy must be dropped
    @(posedge clock_i);
    #1 pin = 1'b1;
    st = st ^ 5'h1b;
    wr({1'b1, cur[14:0]});
    wr(~cur & 16'h7fff);
    rd_chk(cur | 16'h8000);
    for (int n = 0; n < 4000 && busy_o !== 1'b0; n++) @(posedge clock_i);
    rd_chk(cur);
    chk({13'h0000, an_o, spd_o, fdx_o}, exp_mode(cur, pin));
    // Collision test inside loop-back, then with the test turned off
    wr(16'h4000);
    wr(16'h4080);
    tx_set(1'b1);
    for (int n = 0; n < 1024 && col_o !== 1'b1; n++) @(posedge clock_i);
    chk({15'h0000, col_o}, 16'h0001);
    tx_set(1'b0);
    repeat (8) @(posedge clock_i);
    chk({15'h0000, col_o}, 16'h0000);
    wr(16'h4000);
    tx_set(1'b1);
    repeat (40) @(posedge clock_i);
    chk({15'h0000, col_o}, 16'h0000);
    tx_set(1'b0);
    do_reset();
    print_verdict();
  end

  // Watchdog sized well above the expected run of about 159 us
  initial begin
    #400_000;
    n_fail++;
    print_verdict();
  end
endmodule // testbench
